// [mbc_pkg.sv]
// mbc_pkg: constants and types shared by the memory barrier control files
// assumes: nothing beyond a SystemVerilog-2012 compiler
package mbc_pkg;

  // barrier type field of the barrier instruction
  localparam int unsigned TYPE_LSB = 6;
  localparam int unsigned TYPE_MSB = 10;
  localparam int unsigned TYPE_W = 5;

  localparam logic [4:0] TYPE_FULL = 5'h00;
  localparam logic [4:0] TYPE_INTV = 5'h02;
  localparam logic [4:0] TYPE_MEM = 5'h03;
  localparam logic [4:0] TYPE_STORE_ORD = 5'h04;
  localparam logic [4:0] TYPE_FULL_ORD = 5'h10;
  localparam logic [4:0] TYPE_ACQUIRE = 5'h11;
  localparam logic [4:0] TYPE_RELEASE = 5'h12;
  localparam logic [4:0] TYPE_LOAD_ORD = 5'h13;

  // wishbone register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;

  // control register fields
  localparam int unsigned CTRL_COH_EN_BIT = 0;
  localparam int unsigned CTRL_TYPE_SEL_BIT = 1;
  localparam int unsigned CTRL_EXT_SUPPRESS_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // status register fields
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_STALL_BIT = 1;
  localparam int unsigned STAT_KIND_LSB = 2;

  localparam logic [31:0] BUS_UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    MBC_KIND_NONE,
    MBC_KIND_LEGACY,
    MBC_KIND_INTV,
    MBC_KIND_MEM,
    MBC_KIND_ORDER
  } mbc_kind_t;

  typedef enum {
    MBC_IDLE,
    MBC_FLUSH,
    MBC_REQ,
    MBC_WAIT_RESP,
    MBC_DRAIN_READS,
    MBC_ORDER,
    MBC_DONE
  } mbc_state_t;

endpackage : mbc_pkg

// [mbc_decode.sv]
// mbc_decode: turns a raw barrier type into the barrier kind to perform
// assumes: coherence enable and type select come from the control register
`timescale 1ns/1ps
`default_nettype none
module mbc_decode
  import mbc_pkg::*;
(
  input wire logic [4:0] i_type,
  input wire logic i_coh_en,
  input wire logic i_type_sel,
  output mbc_kind_t o_kind,
  output logic o_old_ld,
  output logic o_old_st,
  output logic o_young_ld,
  output logic o_young_st
);

  logic [4:0] eff_type;

  always_comb begin
    eff_type = i_type;
    // reserved and undefined codes fall back to the full barrier
    case (i_type)
      TYPE_FULL, TYPE_INTV, TYPE_MEM, TYPE_STORE_ORD, TYPE_FULL_ORD,
      TYPE_ACQUIRE, TYPE_RELEASE, TYPE_LOAD_ORD: eff_type = i_type;
      default: eff_type = TYPE_FULL;
    endcase
    if (!i_coh_en && (eff_type == TYPE_INTV || eff_type == TYPE_MEM)) begin
      eff_type = TYPE_FULL;
    end
    if (i_coh_en && eff_type == TYPE_FULL) begin
      eff_type = i_type_sel ? TYPE_MEM : TYPE_INTV;
    end
  end

  always_comb begin
    o_kind = MBC_KIND_ORDER;
    o_old_ld = 1'b1;
    o_old_st = 1'b1;
    o_young_ld = 1'b1;
    o_young_st = 1'b1;
    case (eff_type)
      TYPE_FULL: o_kind = MBC_KIND_LEGACY;
      TYPE_INTV: o_kind = MBC_KIND_INTV;
      TYPE_MEM: o_kind = MBC_KIND_MEM;
      TYPE_STORE_ORD: begin
        o_old_ld = 1'b0;
        o_young_ld = 1'b0;
      end
      TYPE_FULL_ORD: o_kind = MBC_KIND_ORDER;
      TYPE_ACQUIRE: o_old_st = 1'b0;
      TYPE_RELEASE: o_young_ld = 1'b0;
      TYPE_LOAD_ORD: begin
        o_old_st = 1'b0;
        o_young_st = 1'b0;
      end
      default: o_kind = MBC_KIND_LEGACY;
    endcase
  end

endmodule // mbc_decode
`default_nettype wire

// [mbc_wb_regs.sv]
// mbc_wb_regs: classic wishbone slave holding the barrier control register
// assumes: single-cycle classic master; answers one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module mbc_wb_regs
  import mbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] adr,
  input wire logic [31:0] dat_w,
  input wire logic [3:0] sel,
  input wire logic we,
  input wire logic cyc,
  input wire logic stb,
  output logic [31:0] dat_r,
  output logic ack,
  input wire logic [31:0] status_word,
  input wire logic [31:0] count_word,
  output logic [2:0] ctrl
);

  logic ack_reg;
  logic [31:0] dat_r_reg;
  logic [2:0] ctrl_reg;
  logic req;

  // ack drops for a cycle after each answer so one request gives one ack
  assign req = cyc && stb && !ack_reg;
  assign ack = ack_reg;
  assign dat_r = dat_r_reg;
  assign ctrl = ctrl_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (req && we && adr == ADDR_CTRL && sel[0]) begin
      ctrl_reg <= dat_w[2:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dat_r_reg <= 32'h0000_0000;
    end else if (req && !we) begin
      case (adr)
        ADDR_CTRL: dat_r_reg <= {29'h0000_0000, ctrl_reg};
        ADDR_STATUS: dat_r_reg <= status_word;
        ADDR_COUNT: dat_r_reg <= count_word;
        default: dat_r_reg <= BUS_UNMAPPED_DATA;
      endcase
    end
  end

endmodule // mbc_wb_regs
`default_nettype wire

// [mbc_top.sv]
// mbc_top: memory barrier control for one core
// assumes: pipeline holds the barrier instruction until o_BAR_DONE pulses;
// the coherence hub keeps its request/response handshake
//
// Notes on behaviour
// - coherent intervention barrier: request hub, hold until it responds
// - coherence off: types 2 and 3 act like type 0
// - coherent memory barrier: request hub, then memory unit, flush outward
// - memory barrier emits external barrier if support=1 and suppress=0
// - coherence on: type 0 becomes type 2 or 3 by select bit
// - coherence off: type 0 is a legacy request straight to memory
// - legacy barrier emits external barrier if support=1 and suppress=0
// - ordering barrier: older covered ops pass ordering stage first
// - older external requests globally performed before younger ones
// - ordering barriers never stall or reorder instruction fetch
// - ordering barriers: finish evictions, stop merging, no request
// - cache and prefetch ops obey barriers like loads and stores
// - type is instruction bits 10:6; unlisted codes are reserved
// - completion types: older ops globally performed before younger start
// - older ops per ordering type reach ordering point before completion
// - younger ops per ordering type held until completion
// - completion barriers flush writes, request, await reads and response
// - undefined non-zero types act as the full completion barrier
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mbc_top
  import mbc_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // barrier instruction from issue
  input wire logic I_BAR_VALID,
  input wire logic [31:0] I_BAR_INSTR,
  output logic O_BAR_READY,
  output logic O_BAR_DONE,
  // load/store datapath and bus interface
  input wire logic I_WRITES_PENDING,
  input wire logic I_READS_PENDING,
  input wire logic I_OLD_LD_ORDERED,
  input wire logic I_OLD_ST_ORDERED,
  input wire logic I_EVICT_PENDING,
  output logic O_FLUSH_WRITES,
  output logic O_FINISH_EVICT,
  output logic O_STOP_MERGE,
  output logic O_STALL_YOUNG_LD,
  output logic O_STALL_YOUNG_ST,
  output logic O_STALL_FETCH,
  // coherence hub
  output logic O_COH_REQ,
  output logic O_COH_MEM_BARRIER,
  output logic O_COH_EXT_EN,
  input wire logic I_COH_ACCEPT,
  input wire logic I_COH_RESP,
  // memory unit legacy path
  output logic O_LEGACY_REQ,
  output logic O_LEGACY_EXT_EN,
  input wire logic I_LEGACY_ACCEPT,
  input wire logic I_LEGACY_RESP,
  input wire logic I_NEXT_LEVEL_SYNC_SUPPORT_IN,
  // wishbone slave
  input wire logic [7:0] I_WB_ADR,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [3:0] I_WB_SEL,
  input wire logic I_WB_WE,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK
);

  mbc_state_t state_reg;
  mbc_state_t state_next;
  mbc_kind_t kind_reg;
  mbc_kind_t dec_kind;
  logic [2:0] ctrl;
  logic dec_old_ld, dec_old_st, dec_young_ld, dec_young_st;
  logic old_ld_reg, old_st_reg, young_ld_reg, young_st_reg;
  logic ext_en_reg;
  logic accepted_reg;
  logic [15:0] count_reg;
  logic [31:0] status_word;
  logic take;
  logic is_coh;
  logic resp_in;
  logic old_ok;

  mbc_decode u_decode (
    .i_type(I_BAR_INSTR[TYPE_MSB:TYPE_LSB]),
    .i_coh_en(ctrl[CTRL_COH_EN_BIT]),
    .i_type_sel(ctrl[CTRL_TYPE_SEL_BIT]),
    .o_kind(dec_kind),
    .o_old_ld(dec_old_ld),
    .o_old_st(dec_old_st),
    .o_young_ld(dec_young_ld),
    .o_young_st(dec_young_st)
  );

  assign status_word = {27'h000_0000, 3'(kind_reg),
    (O_STALL_YOUNG_LD | O_STALL_YOUNG_ST), (state_reg != MBC_IDLE)};

  mbc_wb_regs u_regs (
    .clk(I_SYS_CLK),
    .rst_n(I_RST_N),
    .adr(I_WB_ADR),
    .dat_w(I_WB_DAT),
    .sel(I_WB_SEL),
    .we(I_WB_WE),
    .cyc(I_WB_CYC),
    .stb(I_WB_STB),
    .dat_r(O_WB_DAT),
    .ack(O_WB_ACK),
    .status_word(status_word),
    .count_word({16'h0000, count_reg}),
    .ctrl(ctrl)
  );

  assign take = I_BAR_VALID && (state_reg == MBC_IDLE);
  assign O_BAR_READY = (state_reg == MBC_IDLE);
  assign is_coh = (kind_reg == MBC_KIND_INTV) || (kind_reg == MBC_KIND_MEM);
  assign resp_in = is_coh ? I_COH_RESP : I_LEGACY_RESP;
  // cache, prefetch ops report through the same ordered flags
  assign old_ok = (!old_ld_reg || I_OLD_LD_ORDERED) &&
                  (!old_st_reg || I_OLD_ST_ORDERED);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MBC_IDLE: begin
        if (take) begin
          state_next = (dec_kind == MBC_KIND_ORDER) ? MBC_ORDER : MBC_FLUSH;
        end
      end
      MBC_FLUSH: begin
        if (!I_WRITES_PENDING) begin
          state_next = MBC_REQ;
        end
      end
      MBC_REQ: begin
        if (is_coh ? I_COH_ACCEPT : I_LEGACY_ACCEPT) begin
          state_next = MBC_WAIT_RESP;
        end
      end
      MBC_WAIT_RESP: begin
        if (resp_in && accepted_reg) begin
          state_next = MBC_DRAIN_READS;
        end
      end
      MBC_DRAIN_READS: begin
        if (!I_READS_PENDING) begin
          state_next = MBC_DONE;
        end
      end
      MBC_ORDER: begin
        if (old_ok && !I_EVICT_PENDING) begin
          state_next = MBC_DONE;
        end
      end
      MBC_DONE: state_next = MBC_IDLE;
      default: state_next = MBC_IDLE;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= MBC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      kind_reg <= MBC_KIND_NONE;
      old_ld_reg <= 1'b0;
      old_st_reg <= 1'b0;
      young_ld_reg <= 1'b0;
      young_st_reg <= 1'b0;
      ext_en_reg <= 1'b0;
    end else if (take) begin
      kind_reg <= dec_kind;
      old_ld_reg <= dec_old_ld;
      old_st_reg <= dec_old_st;
      young_ld_reg <= dec_young_ld;
      young_st_reg <= dec_young_st;
      // intervention and ordering barriers never go external; memory and legacy ones may
      ext_en_reg <= (dec_kind == MBC_KIND_MEM || dec_kind == MBC_KIND_LEGACY)
        && I_NEXT_LEVEL_SYNC_SUPPORT_IN
        && !ctrl[CTRL_EXT_SUPPRESS_BIT];
    end
  end

  // guards against a second response being counted for one request
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      accepted_reg <= 1'b0;
    end else if (state_reg == MBC_REQ && state_next == MBC_WAIT_RESP) begin
      accepted_reg <= 1'b1;
    end else if (state_reg == MBC_WAIT_RESP && resp_in) begin
      accepted_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      count_reg <= 16'h0000;
    end else if (state_reg == MBC_DONE) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // requests are levels held in MBC_REQ until the accept
  assign O_COH_REQ = (state_reg == MBC_REQ) && is_coh;
  assign O_COH_MEM_BARRIER = (kind_reg == MBC_KIND_MEM) && is_coh
    && (state_reg == MBC_REQ);
  assign O_COH_EXT_EN = O_COH_REQ && ext_en_reg;
  assign O_LEGACY_REQ = (state_reg == MBC_REQ) &&
    (kind_reg == MBC_KIND_LEGACY);
  assign O_LEGACY_EXT_EN = O_LEGACY_REQ && ext_en_reg;

  // writes drained outward for every completion barrier
  assign O_FLUSH_WRITES = (state_reg == MBC_FLUSH) ||
    (state_reg == MBC_REQ);
  assign O_FINISH_EVICT = (state_reg == MBC_ORDER);
  assign O_STOP_MERGE = (state_reg == MBC_ORDER);

  // stall drops once the response is in and no reads are pending, in MBC_DRAIN_READS or MBC_DONE
  always_comb begin
    O_STALL_YOUNG_LD = 1'b0;
    O_STALL_YOUNG_ST = 1'b0;
    if (state_reg != MBC_IDLE && state_reg != MBC_DONE) begin
      if (kind_reg == MBC_KIND_ORDER) begin
        O_STALL_YOUNG_LD = young_ld_reg;
        O_STALL_YOUNG_ST = young_st_reg;
      end else if (state_reg != MBC_DRAIN_READS || I_READS_PENDING) begin
        O_STALL_YOUNG_LD = 1'b1;
        O_STALL_YOUNG_ST = 1'b1;
      end
    end
  end

  assign O_STALL_FETCH = 1'b0;
  assign O_BAR_DONE = (state_reg == MBC_DONE);

endmodule // mbc_top
`default_nettype wire

// [mbc_assertions.sv]
// mbc_assertions: port-level checks of the barrier control top
// assumes: bound to mbc_top; one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module mbc_assertions (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic O_BAR_READY,
  input wire logic O_BAR_DONE,
  input wire logic O_FLUSH_WRITES,
  input wire logic O_FINISH_EVICT,
  input wire logic O_STOP_MERGE,
  input wire logic O_STALL_YOUNG_LD,
  input wire logic O_STALL_YOUNG_ST,
  input wire logic O_STALL_FETCH,
  input wire logic O_COH_REQ,
  input wire logic O_COH_MEM_BARRIER,
  input wire logic O_COH_EXT_EN,
  input wire logic I_COH_ACCEPT,
  input wire logic O_LEGACY_REQ,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic O_WB_ACK
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  AST_WB_ANSWER: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK
    |=> O_WB_ACK) else $error("bus request not answered next cycle");
  AST_DONE_PULSE: assert property (O_BAR_DONE
    |=> !O_BAR_DONE && O_BAR_READY) else $error("done not a single pulse");
  AST_FETCH_FREE: assert property (!O_STALL_FETCH)
    else $error("fetch stalled by a barrier");
  AST_REQ_HOLD: assert property (O_COH_REQ && !I_COH_ACCEPT
    |=> O_COH_REQ) else $error("hub request dropped before accept");
  AST_REQ_BUSY: assert property (O_COH_REQ |-> !O_BAR_READY)
    else $error("barrier released while hub request open");
  AST_ORDER_QUIET: assert property (O_STOP_MERGE
    |-> !O_COH_REQ && !O_LEGACY_REQ) else $error("ordering raised request");
  AST_EXT_MEM_ONLY: assert property (O_COH_REQ && O_COH_EXT_EN
    |-> O_COH_MEM_BARRIER) else $error("external barrier on wrong type");
  AST_ONE_PATH: assert property (!(O_COH_REQ && O_LEGACY_REQ))
    else $error("coherent and legacy request together");
  AST_REQ_STALLS: assert property (O_COH_REQ || O_LEGACY_REQ
    |-> O_STALL_YOUNG_LD && O_STALL_YOUNG_ST)
    else $error("younger ops not stalled during completion barrier");
  AST_ORDER_MERGE: assert property (O_FINISH_EVICT == O_STOP_MERGE)
    else $error("eviction finish and merge stop disagree");
  AST_REQ_FLUSH: assert property (O_COH_REQ || O_LEGACY_REQ
    |-> O_FLUSH_WRITES) else $error("writes not flushed during request");
endmodule // mbc_assertions

bind mbc_top mbc_assertions u_chk (.*);
`default_nettype wire

// [mbc_hub_model.sv]
// mbc_hub_model: accept/response partner for one barrier request path
// assumes: request is a level held until accept; i_lat sets the pace
`timescale 1ns/1ps
`default_nettype none
module mbc_hub_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] i_lat,
  input wire logic i_req,
  output logic o_accept,
  output logic o_resp
);
  logic busy_reg;
  logic [3:0] cnt_reg;

  // the latency stands in for older interventions and external replies
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'h0;
      cnt_reg <= 4'h0;
      o_accept <= 1'h0;
      o_resp <= 1'h0;
    end else begin
      o_accept <= 1'h0;
      o_resp <= 1'h0;
      if (busy_reg || (i_req && !o_accept)) begin
        if (cnt_reg < i_lat) begin
          cnt_reg <= cnt_reg + 4'h1;
        end else begin
          cnt_reg <= 4'h0;
          busy_reg <= !busy_reg;
          o_resp <= busy_reg;
          o_accept <= !busy_reg;
        end
      end
    end
  end
endmodule // mbc_hub_model
`default_nettype wire

// [memory_barrier_control_tb.sv]
// memory_barrier_control_tb: self-checking bench for mbc_top
// assumes: hub and legacy paths answered by mbc_hub_model instances
`timescale 1ns/1ps
`default_nettype none
module memory_barrier_control_tb
  import mbc_pkg::*;
;
  logic I_SYS_CLK, I_RST_N, I_BAR_VALID, O_BAR_READY, O_BAR_DONE;
  logic [31:0] I_BAR_INSTR, I_WB_DAT, O_WB_DAT, q;
  logic I_WRITES_PENDING, I_READS_PENDING, I_OLD_LD_ORDERED;
  logic I_OLD_ST_ORDERED, I_EVICT_PENDING, O_FLUSH_WRITES, O_FINISH_EVICT;
  logic O_STOP_MERGE, O_STALL_YOUNG_LD, O_STALL_YOUNG_ST, O_STALL_FETCH;
  logic O_COH_REQ, O_COH_MEM_BARRIER, O_COH_EXT_EN, I_COH_ACCEPT;
  logic I_COH_RESP, O_LEGACY_REQ, O_LEGACY_EXT_EN, I_LEGACY_ACCEPT;
  logic I_LEGACY_RESP, I_NEXT_LEVEL_SYNC_SUPPORT_IN, I_WB_WE, I_WB_CYC;
  logic I_WB_STB, O_WB_ACK, mon, early, held;
  logic [7:0] I_WB_ADR, seen;
  logic [3:0] I_WB_SEL, lat;
  logic [4:0] ts [10] = '{5'h04, 5'h10, 5'h11, 5'h12, 5'h13,
                         5'h01, 5'h05, 5'h0F, 5'h14, 5'h1F};
  int fails, checked, cycles, nbar;

  mbc_top u_dut (.*);
  mbc_hub_model u_coh (.clk(I_SYS_CLK), .rst_n(I_RST_N), .i_lat(lat),
    .i_req(O_COH_REQ), .o_accept(I_COH_ACCEPT), .o_resp(I_COH_RESP));
  mbc_hub_model u_leg (.clk(I_SYS_CLK), .rst_n(I_RST_N), .i_lat(lat),
    .i_req(O_LEGACY_REQ), .o_accept(I_LEGACY_ACCEPT),
    .o_resp(I_LEGACY_RESP));

  initial begin
    I_SYS_CLK = 1'h0;
    forever #50 I_SYS_CLK = ~I_SYS_CLK;
  end

  task finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge I_SYS_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  // collect what the block did over one barrier
  always @(negedge I_SYS_CLK) begin
    if (mon) begin
      seen <= seen | {O_COH_REQ, O_LEGACY_REQ, O_COH_REQ & O_COH_MEM_BARRIER,
        (O_COH_REQ & O_COH_EXT_EN) | (O_LEGACY_REQ & O_LEGACY_EXT_EN),
        O_STALL_YOUNG_LD, O_STALL_YOUNG_ST, O_FLUSH_WRITES, O_FINISH_EVICT};
      if (O_BAR_DONE && held) begin
        early <= 1'h1;
      end
    end
  end

  task automatic chk(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge I_SYS_CLK);
    {I_WB_CYC, I_WB_STB, I_WB_WE} <= {2'h3, w};
    I_WB_ADR <= a;
    I_WB_DAT <= d;
    do @(posedge I_SYS_CLK); while (O_WB_ACK !== 1'h1);
    r = O_WB_DAT;
    {I_WB_CYC, I_WB_STB, I_WB_WE} <= 3'h0;
  endtask

  // mode bits: coherence, type select, suppress, next-level support
  function automatic logic [7:0] f_exp(input logic [3:0] m,
                                       input logic [4:0] t);
    logic [4:0] e;
    logic ext;
    ext = m[0] & ~m[1];
    e = t;
    if (!(t inside {5'h02, 5'h03, 5'h04, [5'h10:5'h13]})) e = 5'h00;
    if (!m[3] && e inside {5'h02, 5'h03}) e = 5'h00;
    if (m[3] && e == 5'h00) e = m[2] ? 5'h03 : 5'h02;
    case (e)
      5'h00: return {3'h2, ext, 4'hE};
      5'h02: return 8'h8E;
      5'h03: return {3'h5, ext, 4'hE};
      5'h04, 5'h12: return 8'h05;
      5'h13: return 8'h09;
      default: return 8'h0D;
    endcase
  endfunction

  // pending work is held several cycles so early completion shows
  task automatic run_bar(input logic [3:0] m, input logic [4:0] t);
    int n;
    wb(1'h1, ADDR_CTRL, {29'h0, m[1], m[2], m[3]}, q);
    @(posedge I_SYS_CLK);
    I_NEXT_LEVEL_SYNC_SUPPORT_IN <= m[0];
    I_BAR_INSTR <= {21'h0, t, 6'h0F};
    {I_BAR_VALID, I_WRITES_PENDING, I_READS_PENDING} <= 3'h7;
    {I_EVICT_PENDING, I_OLD_LD_ORDERED, I_OLD_ST_ORDERED} <= 3'h4;
    {held, mon, early, seen} <= {3'h6, 8'h00};
    do @(posedge I_SYS_CLK); while (O_BAR_READY !== 1'h1);
    I_BAR_VALID <= 1'h0;
    repeat (3) @(posedge I_SYS_CLK);
    // evictions end first: ordering must still wait for the older ops
    {I_WRITES_PENDING, I_EVICT_PENDING} <= 2'h0;
    repeat (3) @(posedge I_SYS_CLK);
    {I_READS_PENDING, held} <= 2'h0;
    {I_OLD_LD_ORDERED, I_OLD_ST_ORDERED} <= 2'h3;
    n = 0;
    while (O_BAR_DONE !== 1'h1 && n < 60) begin
      @(posedge I_SYS_CLK);
      n++;
    end
    mon <= 1'h0;
    nbar++;
    chk(32'(n < 60), 32'h1, "barrier finished");
    chk({24'h0, seen}, {24'h0, f_exp(m, t)}, "barrier actions");
    chk(32'(early), 32'h0, "done with work pending");
  endtask

  task t_regs;
    wb(1'h0, ADDR_CTRL, 32'h0, q);
    chk(q, {29'h0, CTRL_RESET}, "control reset");
    wb(1'h1, ADDR_CTRL, 32'h7, q);
    I_WB_SEL <= 4'h0;
    wb(1'h1, ADDR_CTRL, 32'h0, q);
    I_WB_SEL <= 4'hF;
    wb(1'h0, ADDR_CTRL, 32'h0, q);
    chk(q, 32'h7, "control write without lane");
    wb(1'h0, 8'h0C, 32'h0, q);
    chk(q, BUS_UNMAPPED_DATA, "unmapped read");
    wb(1'h0, ADDR_STATUS, 32'h0, q);
    chk(q & 32'h3, 32'h0, "idle status");
  endtask

  // reset lands while a barrier waits in the flush phase
  task t_reset;
    wb(1'h1, ADDR_CTRL, 32'h1, q);
    @(posedge I_SYS_CLK);
    {I_BAR_VALID, I_WRITES_PENDING} <= 2'h3;
    do @(posedge I_SYS_CLK); while (O_BAR_READY !== 1'h1);
    I_BAR_VALID <= 1'h0;
    repeat (3) @(posedge I_SYS_CLK);
    chk(32'(O_STALL_YOUNG_LD), 32'h1, "stall while flushing");
    chk(32'(O_FLUSH_WRITES), 32'h1, "flush while pending");
    I_RST_N <= 1'h0;
    I_WRITES_PENDING <= 1'h0;
    repeat (2) @(posedge I_SYS_CLK);
    chk(32'(O_BAR_READY), 32'h1, "ready in reset");
    chk(32'(O_FLUSH_WRITES), 32'h0, "flush in reset");
    I_RST_N <= 1'h1;
    wb(1'h0, ADDR_CTRL, 32'h0, q);
    chk(q, {29'h0, CTRL_RESET}, "control after reset");
  endtask

  task t_legacy;
    run_bar(4'h1, 5'h00);
    run_bar(4'h3, 5'h00);
    run_bar(4'h0, 5'h00);
    run_bar(4'h1, 5'h02);
    run_bar(4'h5, 5'h03);
  endtask

  task t_coherent;
    run_bar(4'h9, 5'h00);
    run_bar(4'hD, 5'h00);
    run_bar(4'hF, 5'h00);
    lat <= 4'h5;
    run_bar(4'h9, 5'h02);
    run_bar(4'h9, 5'h03);
    lat <= 4'h0;
    run_bar(4'h8, 5'h03);
  endtask

  task t_types;
    for (int i = 0; i < 10; i++) begin
      run_bar(4'h0, ts[i]);
      run_bar(4'hD, ts[i]);
    end
    wb(1'h0, ADDR_COUNT, 32'h0, q);
    chk({16'h0, q[15:0]}, {16'h0, nbar[15:0]}, "completed count");
  endtask

  initial begin
    {I_RST_N, I_BAR_VALID, I_WRITES_PENDING, I_READS_PENDING, I_EVICT_PENDING,
     I_OLD_LD_ORDERED, I_OLD_ST_ORDERED, I_NEXT_LEVEL_SYNC_SUPPORT_IN, I_WB_WE,
     I_WB_CYC, I_WB_STB, mon, early, held} = '0;
    {I_BAR_INSTR, I_WB_DAT, I_WB_ADR, seen, lat} = '0;
    I_WB_SEL = 4'hF;
    {fails, checked, cycles, nbar} = '0;
    repeat (6) @(posedge I_SYS_CLK);
    I_RST_N <= 1'h1;
    t_regs();
    t_reset();
    t_legacy();
    t_coherent();
    t_types();
    finish_test();
  end
endmodule // memory_barrier_control_tb
`default_nettype wire
